/* logic/pattern_out_pkg.sv */
// Functional notes
// - Counter increments on each external rising edge; compare value programmed to zero.
// - Count source is the external count pin when selected, else internal prescaler.
// - Counter clears when count equals compare A, so zero matches every edge.
// - Compare A works with timer pin output disabled, match is internal trigger.
// - Status flag shows compare match or overflow, readable by software.
// - Counting starts only after the start bit is set.
// - Each compare A match updates the 12-bit pattern output.
// - Outputs form 4-bit groups: 11..8 group 2, 7..4 group 1, 3..0 group 0.
// - Per-group trigger select picks channel 0 match as output trigger.
// - Mode register selects normal or other operation per group.
// - Two 8-bit enables gate next-data transfer per bit, hi 15..8, lo 7..0.
// - Output data registers hold driven pattern; hi groups 2,3, lo groups 0,1.
// - Each match activates DMA, copying next table entry into next-data.
// - DMA source is memory address register, destination fixed I/O address.
// - DMA counts transfers; end interrupt when exhausted; separate enable bits.
package pattern_out_pkg;
  localparam logic [7:0] OFF_START = 8'h00;
  localparam logic [7:0] OFF_TCTRL = 8'h04;
  localparam logic [7:0] OFF_TIOC = 8'h08;
  localparam logic [7:0] OFF_CMPA = 8'h0C;
  localparam logic [7:0] OFF_TCNT = 8'h10;
  localparam logic [7:0] OFF_STAT = 8'h14;
  localparam logic [7:0] OFF_MASK = 8'h18;
  localparam logic [7:0] OFF_OUT_HI = 8'h1C;
  localparam logic [7:0] OFF_OUT_LO = 8'h20;
  localparam logic [7:0] OFF_NXT_HI = 8'h24;
  localparam logic [7:0] OFF_NXT_LO = 8'h28;
  localparam logic [7:0] OFF_NEN_HI = 8'h2C;
  localparam logic [7:0] OFF_NEN_LO = 8'h30;
  localparam logic [7:0] OFF_TRIG = 8'h34;
  localparam logic [7:0] OFF_MODE = 8'h38;
  localparam logic [7:0] OFF_DBAND = 8'h3C;
  localparam logic [7:0] OFF_DMAR = 8'h40;
  localparam logic [7:0] OFF_DIOAR = 8'h44;
  localparam logic [7:0] OFF_DCNT = 8'h48;
  localparam logic [7:0] OFF_TABLE = 8'h80;
  localparam int TABLE_DEPTH = 16;
  localparam logic [15:0] CMPA_RESET = 16'h0000;
  localparam logic [15:0] DIOAR_RESET = 16'h0000;
  localparam logic [2:0] PRESCALE_LAST = 3'h7;
  localparam int ST_CMPA = 0;
  localparam int ST_OVF = 1;
  localparam int ST_DEND = 2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef struct packed {
    logic clr_on_cmpa;
    logic ext_sel;
  } timer_ctrl_t;
  typedef struct packed {
    logic end_irq_en;
    logic xfer_en;
  } dma_ctrl_t;
  typedef enum logic [1:0] {
    W_IDLE = 2'b00,
    W_RESP = 2'b01
  } wr_state_t;
endpackage : pattern_out_pkg

/* logic/timer_channel.sv */
`timescale 1ns/10ps
module timer_channel #(
  parameter int WIDTH = 16
) (
  input wire logic aclk, // System clock
  input wire logic aresetn, // Synchronous reset, active low
  input wire logic count_en, // One count event
  input wire logic clr_on_cmp, // Clear counter on compare match
  input wire logic [WIDTH-1:0] compare, // Compare A value
  input wire logic load, // Software write of counter
  input wire logic [WIDTH-1:0] load_val, // Value written
  output logic [WIDTH-1:0] count, // Counter
  output logic match, // Compare match pulse
  output logic overflow // Overflow pulse
);
  logic [WIDTH-1:0] count_next;
  logic wrap;

  // Next count and clear decision
  always_comb begin
    wrap = &count;
    if (clr_on_cmp && count == compare) begin
      count_next = '0;
    end else begin
      count_next = count + 1'b1;
    end
  end

  // Counter with match and overflow pulses
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count <= '0;
      match <= 1'b0;
      overflow <= 1'b0;
    end else begin
      match <= 1'b0;
      overflow <= 1'b0;
      if (load) begin
        count <= load_val;
      end else if (count_en) begin
        count <= count_next;
        match <= (count_next == compare);
        overflow <= wrap && !(clr_on_cmp && count == compare);
      end
    end
  end
endmodule : timer_channel

/* logic/pattern_group.sv */
`timescale 1ns/10ps
module pattern_group (
  input wire logic aclk, // System clock
  input wire logic aresetn, // Synchronous reset, active low
  input wire logic trigger, // Selected compare match
  input wire logic normal_mode, // Group in normal output mode
  input wire logic [3:0] enable, // Next-data enables
  input wire logic [3:0] next_data, // Next pattern nibble
  input wire logic load, // Software write of output data
  input wire logic [3:0] load_val, // Value written
  output logic [3:0] out_bits // Driven pattern nibble
);
  // Output nibble, software write or masked trigger copy
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_bits <= 4'h0;
    end else if (trigger && normal_mode) begin
      out_bits <= (next_data & enable) | (out_bits & ~enable);
    end else if (load) begin
      out_bits <= load_val;
    end
  end
endmodule : pattern_group

/* logic/edge_pattern_out.sv */
// Chosen here: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/10ps
module edge_pattern_out (
  input wire logic aclk, // System clock, 10 MHz
  input wire logic aresetn, // Synchronous reset, active low
  input wire logic ext_count_clock_pin, // External strobe input
  input wire logic [7:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write byte strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [7:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  output logic [11:0] pattern_output_bits, // Pattern pins
  output logic timer_pin_out, // Compare output pin
  output logic irq // Level interrupt
);
  import pattern_out_pkg::*;

  logic start_reg;
  pattern_out_pkg::timer_ctrl_t tctrl_reg;
  logic tioc_reg;
  logic [15:0] cmpa_reg;
  logic [2:0] stat_reg;
  logic [2:0] mask_reg;
  logic [15:0] nxt_reg;
  logic [15:0] nen_reg;
  logic [7:0] trig_reg;
  logic [3:0] mode_reg;
  pattern_out_pkg::dma_ctrl_t dband_reg;
  logic [15:0] dmar_reg;
  logic [15:0] dioar_reg;
  logic [15:0] dcnt_reg;
  logic [15:0] table_mem [TABLE_DEPTH];
  logic [15:0] out_data;
  logic [15:0] tcnt;
  logic cmp_match;
  logic ovf;
  logic pin_d;
  logic [2:0] div_reg;
  logic tick;
  logic count_en;
  logic [3:0] grp_trig;
  logic [7:0] aw_addr_reg;
  logic aw_have;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic w_have;
  wr_state_t wr_state;
  logic wr_fire;
  logic [7:0] wa;
  logic [31:0] wd;
  logic [31:0] rd_next;
  logic rd_map;
  logic rd_fire;
  logic stat_rd;
  logic dma_go;
  logic dma_last;

  // Internal prescaler enable, one pulse in eight
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_reg <= 3'h0;
      pin_d <= 1'b0;
    end else begin
      div_reg <= div_reg + 3'h1;
      pin_d <= ext_count_clock_pin;
    end
  end
  assign tick = (div_reg == PRESCALE_LAST);

  assign count_en = start_reg && (tctrl_reg.ext_sel ? (ext_count_clock_pin && !pin_d) : tick);

  timer_channel #(
    .WIDTH(16)
  ) u_timer (
    .aclk(aclk),
    .aresetn(aresetn),
    .count_en(count_en),
    .clr_on_cmp(tctrl_reg.clr_on_cmpa),
    .compare(cmpa_reg),
    .load(wr_fire && wa == OFF_TCNT),
    .load_val(wd[15:0]),
    .count(tcnt),
    .match(cmp_match),
    .overflow(ovf)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer_pin_out <= 1'b0;
    end else if (cmp_match && tioc_reg) begin
      timer_pin_out <= ~timer_pin_out;
    end
  end

  // Pattern groups; only channel 0 exists so select code zero triggers
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : gen_grp
      assign grp_trig[g] = cmp_match && (trig_reg[2*g+1 -: 2] == 2'h0);
      pattern_group u_grp (
        .aclk(aclk),
        .aresetn(aresetn),
        .trigger(grp_trig[g]),
        .normal_mode(!mode_reg[g]),
        .enable(nen_reg[4*g+3 -: 4]),
        .next_data(nxt_reg[4*g+3 -: 4]),
        .load(wr_fire && (wa == (g >= 2 ? OFF_OUT_HI : OFF_OUT_LO))),
        .load_val(wd[4*(g%2)+3 -: 4]),
        .out_bits(out_data[4*g+3 -: 4])
      );
    end
  endgenerate

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pattern_output_bits <= 12'h000;
    end else begin
      pattern_output_bits <= out_data[11:0];
    end
  end

  assign dma_go = cmp_match && dband_reg.xfer_en && (dcnt_reg != 16'h0000);
  assign dma_last = (dcnt_reg == 16'h0001);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dband_reg <= '0;
      dmar_reg <= 16'h0000;
      dioar_reg <= DIOAR_RESET;
      dcnt_reg <= 16'h0000;
    end else if (dma_go) begin
      dmar_reg <= dmar_reg + 16'h0001;
      dcnt_reg <= dcnt_reg - 16'h0001;
      if (dma_last) begin
        dband_reg.xfer_en <= 1'b0;
      end
    end else if (wr_fire) begin
      if (wa == OFF_DBAND) dband_reg <= wd[1:0];
      if (wa == OFF_DMAR) dmar_reg <= wd[15:0];
      if (wa == OFF_DIOAR) dioar_reg <= wd[15:0];
      if (wa == OFF_DCNT) dcnt_reg <= wd[15:0];
    end
  end

  // Next data, DMA write wins over software
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      nxt_reg <= 16'h0000;
    end else if (dma_go && dioar_reg[7:0] == OFF_NXT_HI) begin
      nxt_reg <= table_mem[dmar_reg[3:0]];
    end else if (dma_go && dioar_reg[7:0] == OFF_NXT_LO) begin
      nxt_reg[7:0] <= table_mem[dmar_reg[3:0]][7:0];
    end else if (wr_fire && wa == OFF_NXT_HI) begin
      nxt_reg[15:8] <= wd[7:0];
    end else if (wr_fire && wa == OFF_NXT_LO) begin
      nxt_reg[7:0] <= wd[7:0];
    end
  end

  // Pattern table written by software
  always_ff @(posedge aclk) begin
    if (wr_fire && wa[7] && !wa[6] && wa[1:0] == 2'h0) begin
      table_mem[wa[5:2]] <= wd[15:0];
    end
  end

  // Control registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      start_reg <= 1'b0;
      tctrl_reg <= '0;
      tioc_reg <= 1'b0;
      cmpa_reg <= CMPA_RESET;
      mask_reg <= 3'h0;
      nen_reg <= 16'h0000;
      trig_reg <= 8'h00;
      mode_reg <= 4'h0;
    end else if (wr_fire) begin
      if (wa == OFF_START) start_reg <= wd[0];
      if (wa == OFF_TCTRL) tctrl_reg <= wd[1:0];
      if (wa == OFF_TIOC) tioc_reg <= wd[0];
      if (wa == OFF_CMPA) cmpa_reg <= wd[15:0];
      if (wa == OFF_MASK) mask_reg <= wd[2:0];
      if (wa == OFF_NEN_HI) nen_reg[15:8] <= wd[7:0];
      if (wa == OFF_NEN_LO) nen_reg[7:0] <= wd[7:0];
      if (wa == OFF_TRIG) trig_reg <= wd[7:0];
      if (wa == OFF_MODE) mode_reg <= wd[3:0];
    end
  end

  // sticky status, set wins over read clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stat_reg <= 3'h0;
    end else begin
      stat_reg <= (stat_rd ? 3'h0 : stat_reg) | {dma_go && dma_last && dband_reg.end_irq_en, ovf, cmp_match};
    end
  end

  // Interrupt level from unmasked status
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(stat_reg & mask_reg);
    end
  end

  // Write channel capture, address and data in either order
  assign wa = aw_have ? aw_addr_reg : s_axi_awaddr;
  assign wd = w_have ? w_data_reg : s_axi_wdata;
  // Registers change only at the edge where the second half of the write is taken
  assign wr_fire = (wr_state == W_IDLE) && (aw_have || (s_axi_awvalid && s_axi_awready))
    && (w_have || (s_axi_wvalid && s_axi_wready)) && ((w_have ? w_strb_reg : s_axi_wstrb) != 4'h0);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state <= W_IDLE;
      aw_have <= 1'b0;
      w_have <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      unique case (wr_state)
        W_IDLE: begin
          s_axi_awready <= !aw_have && !(s_axi_awvalid && s_axi_awready);
          s_axi_wready <= !w_have && !(s_axi_wvalid && s_axi_wready);
          if (s_axi_awvalid && s_axi_awready) begin
            aw_have <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
          end
          if (s_axi_wvalid && s_axi_wready) begin
            w_have <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
          end
          if ((aw_have || (s_axi_awvalid && s_axi_awready)) && (w_have || (s_axi_wvalid && s_axi_wready))) begin
            wr_state <= W_RESP;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b1;
            // Unaligned, gap and upper table alias places answer with an error, as reads do
            s_axi_bresp <= (wa[1:0] != 2'h0 || (wa > OFF_DCNT && !wa[7]) || wa[7:6] == 2'h3)
              ? RESP_SLVERR : RESP_OKAY;
          end
        end
        W_RESP: begin
          aw_have <= 1'b0;
          w_have <= 1'b0;
          if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            wr_state <= W_IDLE;
          end
        end
        default: begin
          wr_state <= W_IDLE;
        end
      endcase
    end
  end

  // Read mux, reserved bits zero
  always_comb begin
    rd_map = 1'b1;
    rd_next = 32'h0000_0000;
    unique case (s_axi_araddr)
      OFF_START: rd_next[0] = start_reg;
      OFF_TCTRL: rd_next[1:0] = tctrl_reg;
      OFF_TIOC: rd_next[0] = tioc_reg;
      OFF_CMPA: rd_next[15:0] = cmpa_reg;
      OFF_TCNT: rd_next[15:0] = tcnt;
      OFF_STAT: rd_next[2:0] = stat_reg;
      OFF_MASK: rd_next[2:0] = mask_reg;
      OFF_OUT_HI: rd_next[7:0] = out_data[15:8];
      OFF_OUT_LO: rd_next[7:0] = out_data[7:0];
      OFF_NXT_HI: rd_next[7:0] = nxt_reg[15:8];
      OFF_NXT_LO: rd_next[7:0] = nxt_reg[7:0];
      OFF_NEN_HI: rd_next[7:0] = nen_reg[15:8];
      OFF_NEN_LO: rd_next[7:0] = nen_reg[7:0];
      OFF_TRIG: rd_next[7:0] = trig_reg;
      OFF_MODE: rd_next[3:0] = mode_reg;
      OFF_DBAND: rd_next[1:0] = dband_reg;
      OFF_DMAR: rd_next[15:0] = dmar_reg;
      OFF_DIOAR: rd_next[15:0] = dioar_reg;
      OFF_DCNT: rd_next[15:0] = dcnt_reg;
      default: begin
        if (s_axi_araddr[7] && s_axi_araddr[1:0] == 2'h0 && !s_axi_araddr[6]) begin
          rd_next[15:0] = table_mem[s_axi_araddr[5:2]];
        end else begin
          rd_map = 1'b0;
        end
      end
    endcase
  end

  assign rd_fire = s_axi_arvalid && s_axi_arready;
  assign stat_rd = rd_fire && s_axi_araddr == OFF_STAT;

  // Read channel, one cycle from address to data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_next;
      s_axi_rresp <= rd_map ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end else begin
      s_axi_arready <= 1'b1;
    end
  end
endmodule : edge_pattern_out

/* tb/pattern_out_asserts.sv */
`timescale 1ns/10ps
module pattern_out_asserts
  import pattern_out_pkg::*;
(
  input wire logic aclk, // Clock
  input wire logic aresetn, // Reset, active low
  input wire logic ext_count_clock_pin, // Strobe
  input wire logic [7:0] s_axi_awaddr, // AW
  input wire logic s_axi_awvalid, // AW
  input wire logic s_axi_awready, // AW
  input wire logic s_axi_wvalid, // W
  input wire logic s_axi_wready, // W
  input wire logic [1:0] s_axi_bresp, // B
  input wire logic s_axi_bvalid, // B
  input wire logic s_axi_bready, // B
  input wire logic [7:0] s_axi_araddr, // AR
  input wire logic s_axi_arvalid, // AR
  input wire logic s_axi_arready, // AR
  input wire logic [31:0] s_axi_rdata, // R
  input wire logic [1:0] s_axi_rresp, // R
  input wire logic s_axi_rvalid, // R
  input wire logic s_axi_rready, // R
  input wire logic [11:0] pattern_output_bits // Pattern pins
);
  logic pin_q;
  logic rise;
  logic wr_hs;
  // Strobe edge and write handshake as the block sees them
  always_ff @(posedge aclk) begin
    pin_q <= ext_count_clock_pin;
  end
  assign rise = ext_count_clock_pin && !pin_q;
  assign wr_hs = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  write_answer_a: assert property (wr_hs |=> s_axi_bvalid) else $error("no write response");
  write_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  write_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write taken early");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("no read data");
  read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  read_block_a: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken early");
  read_slverr_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr inside {[8'h4C:8'h7F]}
    |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0) else $error("unmapped read answered");
  write_slverr_a: assert property (wr_hs && s_axi_awaddr inside {[8'h4C:8'h7F]} |=> s_axi_bresp == RESP_SLVERR)
    else $error("unmapped write answered");
  pattern_cause_a: assert property ($changed(pattern_output_bits) |-> $past(rise, 2) || $past(rise, 3)
    || $past(wr_hs) || $past(wr_hs, 2)) else $error("pattern changed without cause");
  // Main scenarios
  cover property (rise);
  cover property (s_axi_bvalid && s_axi_bready);
  cover property (s_axi_rvalid && s_axi_rready && s_axi_rresp == RESP_SLVERR);
endmodule : pattern_out_asserts

bind edge_pattern_out pattern_out_asserts chk_u (.aclk, .aresetn, .ext_count_clock_pin, .s_axi_awaddr,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
  .pattern_output_bits);

/* tb/strobe_source.sv */
`timescale 1ns/10ps
module strobe_source (
  input wire logic aclk, // Clock
  input wire logic fire, // Request one strobe
  output logic pin // Strobe line, low between strobes
);
  logic [1:0] hold = 2'h0;
  logic pin_q = 1'b0;
  assign pin = pin_q;
  // Pin high for three cycles per request, then back low
  always @(posedge aclk) begin
    if (fire) begin
      pin_q <= 1'b1;
      hold <= 2'h2;
    end else if (hold != 2'h0) begin
      hold <= hold - 2'h1;
    end else begin
      pin_q <= 1'b0;
    end
  end
endmodule : strobe_source

/* tb/edge_pattern_out_tb_top.sv */
`timescale 1ns/10ps
module edge_pattern_out_tb_top;
  import pattern_out_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic fire = 1'b0;
  logic ext_count_clock_pin;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, timer_pin_out, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [11:0] pattern_output_bits;
  int failures = 0;
  int n_tests = 0;
  logic [7:0] cfg_a [17] = '{OFF_TRIG, OFF_MODE, OFF_NEN_HI, OFF_NEN_LO, OFF_NXT_HI, OFF_NXT_LO, 8'h80, 8'h84,
    8'h88, OFF_DMAR, OFF_DIOAR, OFF_DCNT, OFF_DBAND, OFF_MASK, OFF_TCTRL, OFF_CMPA, OFF_TIOC};
  logic [31:0] cfg_d [17] = '{32'h0, 32'h0, 32'hF, 32'hFF, 32'h0A, 32'hBC, 32'hF123, 32'h0456,
    32'h5789, 32'h0, 32'h24, 32'h3, 32'h3, 32'h4, 32'h3, 32'h0, 32'h0};
  logic [11:0] exp_pat [5] = '{12'hABC, 12'h123, 12'h456, 12'h789, 12'h789};

  always #50 aclk = ~aclk;

  edge_pattern_out dut_u (.aclk, .aresetn, .ext_count_clock_pin, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .pattern_output_bits, .timer_pin_out, .irq);
  strobe_source src_u (.aclk, .fire, .pin(ext_count_clock_pin));

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] v);
    n_tests++;
    if (v !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", n, e, v);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    // Wait for the answer; only the watchdog ends a hang
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk("bresp", er, s_axi_bresp);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    // Wait for the answer; only the watchdog ends a hang
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk("rresp", er, s_axi_rresp);
    chk("rdata", ed, s_axi_rdata);
  endtask : rd

  task automatic strobe();
    @(posedge aclk);
    fire <= 1'b1;
    @(posedge aclk);
    fire <= 1'b0;
    repeat (8) @(posedge aclk);
  endtask : strobe

  // Reset values and unmapped places
  task automatic t_reset();
    rd(OFF_CMPA, 32'(CMPA_RESET), RESP_OKAY);
    rd(OFF_DIOAR, 32'(DIOAR_RESET), RESP_OKAY);
    rd(8'h50, 32'h0, RESP_SLVERR);
    wr(8'h60, 32'h1, RESP_SLVERR);
    chk("pattern", 32'h0, 32'(pattern_output_bits));
  endtask : t_reset

  // Strobes ignored until the start bit is set
  task automatic t_nostart();
    for (int i = 0; i < 17; i++) wr(cfg_a[i], cfg_d[i], RESP_OKAY);
    strobe();
    chk("pattern idle", 32'h0, 32'(pattern_output_bits));
    wr(OFF_START, 32'h1, RESP_OKAY);
  endtask : t_nostart

  // Each strobe shows next data; the table refills it for the first three
  task automatic t_stream();
    for (int i = 0; i < 5; i++) begin
      strobe();
      chk("pattern", 32'(exp_pat[i]), 32'(pattern_output_bits));
      if (i == 0) chk("irq masked", 32'h0, 32'(irq));
      if (i == 2) chk("irq end", 32'h1, 32'(irq));
    end
    rd(OFF_TCNT, 32'h0, RESP_OKAY);
    rd(OFF_DCNT, 32'h0, RESP_OKAY);
    rd(OFF_DMAR, 32'h3, RESP_OKAY);
    rd(OFF_STAT, 32'h5, RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk("irq clear", 32'h0, 32'(irq));
    rd(OFF_STAT, 32'h0, RESP_OKAY);
    rd(OFF_OUT_LO, 32'h89, RESP_OKAY);
    chk("pin out", 32'h0, 32'(timer_pin_out));
  endtask : t_stream

  // Trigger select, frozen group and partial enables
  task automatic t_gate();
    wr(OFF_NXT_HI, 32'h05, RESP_OKAY);
    wr(OFF_NXT_LO, 32'h55, RESP_OKAY);
    wr(OFF_TRIG, 32'h10, RESP_OKAY);
    wr(OFF_MODE, 32'h1, RESP_OKAY);
    wr(OFF_NEN_LO, 32'h3F, RESP_OKAY);
    strobe();
    chk("pattern gated", 32'h799, 32'(pattern_output_bits));
  endtask : t_gate

  // Internal prescaled source, no clear, counter wraps and flags overflow
  task automatic t_internal();
    wr(OFF_TCTRL, 32'h0, RESP_OKAY);
    wr(OFF_MASK, 32'h2, RESP_OKAY);
    wr(OFF_TCNT, 32'hFFFE, RESP_OKAY);
    repeat (24) @(posedge aclk);
    chk("irq ovf", 32'h1, 32'(irq));
    rd(OFF_STAT, 32'h3, RESP_OKAY);
  endtask : t_internal

  task automatic test_done();
    $display("checks %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : test_done

  // Main sequence
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_nostart();
    t_stream();
    t_gate();
    t_internal();
    test_done();
  end

  // Watchdog
  initial begin
    repeat (5000) @(posedge aclk);
    failures++;
    test_done();
  end
endmodule : edge_pattern_out_tb_top
